// file: design/nmh_map.vh
// constants for the first ephemeris message framer
// assumes bit positions count from 1 at the first transmitted bit
`ifndef NMH_MAP_VH
`define NMH_MAP_VH

// ----------------------------------------------------------------
// message layout
// ----------------------------------------------------------------
`define NMH_MSG_BITS 300
`define NMH_PREAMBLE 8'h8b
`define NMH_POS_PREAMBLE 1
`define NMH_POS_CODE 9
`define NMH_POS_TYPE 15
`define NMH_POS_WSC 21
`define NMH_POS_ALERT 38
`define NMH_POS_WEEK 39
`define NMH_POS_HEALTH 52
`define NMH_POS_EPOCH 55
`define NMH_POS_ERRIDX 66
`define NMH_POS_BODY 71
`define NMH_POS_INTEG 272
`define NMH_POS_PHASE 273
`define NMH_POS_CRC 277
`define NMH_EPH1_TYPE 6'h0a
`define NMH_ERRIDX_MAX 5'h0f
`define NMH_ERRIDX_MIN 5'h10
`define NMH_CRC_POLY 24'h864cfb
`define NMH_BODY_BITS 201

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define NMH_CLK_HZ 125000000
`define NMH_BIT_RATE_BPS 50
`define NMH_SYMS_PER_BIT 2
`define NMH_SET_TX_HOURS 2
`define NMH_SET_FIT_HOURS 3
`define NMH_MSG_SECONDS 6
`define NMH_FIFO_DEPTH 32

`endif

// file: design/nmh_fifo.v
// small synchronous fifo holding message symbols before the line
// assumes a single clock; depth is a power of two
`timescale 1ns/10ps
module nmh_fifo #(
	parameter WIDTH = 1,
	parameter DEPTH = 32,
	parameter AW = 5
) (
	input wire i_clk_sys,
	input wire i_rst_n,
	input wire i_in_valid,
	output wire o_in_ready,
	input wire [WIDTH-1:0] i_in_data,
	output wire o_out_valid,
	input wire i_out_ready,
	output reg [WIDTH-1:0] o_out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0] wr_ptr;
	reg [AW:0] rd_ptr;
	reg out_full;
	wire [AW:0] count = wr_ptr - rd_ptr;
	wire mem_empty = (count == {(AW+1){1'b0}});
	wire full = (count == DEPTH);
	wire push = i_in_valid & ~full;
	wire take = ~mem_empty & (~out_full | i_out_ready);

	assign o_in_ready = ~full;
	assign o_out_valid = out_full;

	always @(posedge i_clk_sys) begin
		if (push)
			mem[wr_ptr[AW-1:0]] <= i_in_data;
	end

	// ----------------------------------------------------------------
	// pointers and registered output stage
	// ----------------------------------------------------------------
	always @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_ptr <= {(AW+1){1'b0}};
			rd_ptr <= {(AW+1){1'b0}};
			out_full <= 1'b0;
			o_out_data <= {WIDTH{1'b0}};
		end else begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (take) begin
				o_out_data <= mem[rd_ptr[AW-1:0]];
				rd_ptr <= rd_ptr + 1'b1;
				out_full <= 1'b1;
			end else if (i_out_ready)
				out_full <= 1'b0;
		end
	end
endmodule

// file: design/nmh_framer.v
// framer for the first ephemeris message of the civil nav stream
// assumes the caller loads a data set, then serial bits leave as
// fec symbols through a fifo paced by i_sym_ready at 100 sym/s
//
// Function
// - each data set is sent two hours, first two of three fit hours
// - ephemeris content change always comes with a new reference time
// - first set after upload carries reference time unlike the one before
// - bit 272 is integrity level flag, one means enhanced assurance
// - bit 273 carries the carrier phase relationship indicator
// - bits 39..51 carry 13-bit week count modulo 8192 at set start
// - bits 52,53,54 give health of bands one, two, five; one is bad
// - health bits refresh only at upload or at the first load after reset, when a new set is built
// - bits 55..65 carry the prediction epoch field
// - bits 66..70 carry the ephemeris accuracy index
// - accuracy index is signed two's complement from +15 to -16
// - index is worst expected error over the whole fit interval
// - message starts with preamble 10001011, code, type, 17-bit count
// - message is 300 bits, six seconds, ending in 24-bit crc
// - bit 38 is the alert flag
// - 50 bit/s with rate one-half fec giving 100 symbols/s
`timescale 1ns/10ps
`include "nmh_map.vh"
module nmh_framer (
	input wire i_clk_sys,
	input wire i_rst_n,
	input wire i_load,
	input wire i_upload,
	input wire [12:0] i_week_count,
	input wire [2:0] i_health,
	input wire [10:0] i_epoch,
	input wire [4:0] i_error_bound_index,
	input wire i_integrity_level_flag,
	input wire i_phase_flag,
	input wire [10:0] i_ephemeris_reference_time,
	input wire [200:0] i_body,
	input wire [5:0] i_satellite_code_number,
	input wire i_alert,
	input wire i_start,
	input wire [16:0] i_week_seconds_count,
	input wire i_sym_ready,
	output wire o_start_ready,
	output wire o_busy,
	output reg o_load_refused,
	output reg o_set_expired,
	output reg o_set_stale,
	output wire o_sym_valid,
	output wire [1:0] o_sym
);
	localparam ST_IDLE = 3'b001;
	localparam ST_SEND = 3'b010;
	localparam ST_DONE = 3'b100;
	localparam [63:0] SET_CYCLES = 64'd125000000 * 64'd3600 * `NMH_SET_TX_HOURS;
	localparam [63:0] FIT_CYCLES = 64'd125000000 * 64'd3600 * `NMH_SET_FIT_HOURS;
	localparam [7:0] PRE_BITS = `NMH_PREAMBLE;
	localparam [5:0] TYPE_BITS = `NMH_EPH1_TYPE;

	reg [2:0] state;
	reg [2:0] next_state;
	reg [8:0] bit_pos;
	reg [23:0] crc;
	reg [5:0] fec_sr;
	reg [12:0] week;
	reg [2:0] health;
	reg [10:0] epoch;
	reg [4:0] err_idx;
	reg integ;
	reg phase;
	reg [10:0] ref_time;
	reg [200:0] body;
	reg [5:0] code;
	reg alert;
	reg [16:0] wsc;
	reg have_set;
	reg [43:0] set_age;
	reg data_bit;
	wire fifo_in_ready;
	wire send_bit;
	wire [1:0] fec_sym;
	wire crc_fb;
	wire [8:0] pos = bit_pos + 9'd1;
	wire idx_legal = ($signed(i_error_bound_index) <= $signed(`NMH_ERRIDX_MAX)) &
		($signed(i_error_bound_index) >= $signed(`NMH_ERRIDX_MIN));
	wire body_changed = (i_body != body) | (i_week_count != week) | (i_epoch != epoch);
	// a load is refused if content moved but the reference time did not,
	// or an upload tries to keep the reference time sent before cutover
	wire load_bad = ~idx_legal |
		(have_set & body_changed & (i_ephemeris_reference_time == ref_time)) |
		(i_upload & have_set & (i_ephemeris_reference_time == ref_time));
	wire load_ok = i_load & ~load_bad & (state == ST_IDLE);

	assign o_start_ready = (state == ST_IDLE) & have_set & ~o_set_expired;
	assign o_busy = (state != ST_IDLE);
	assign send_bit = (state == ST_SEND) & fifo_in_ready;

	// ----------------------------------------------------------------
	// bit selection by position
	// ----------------------------------------------------------------
	always @* begin
		data_bit = 1'b0;
		if (pos < `NMH_POS_CODE)
			data_bit = PRE_BITS[`NMH_POS_CODE - 1 - pos];
		else if (pos < `NMH_POS_TYPE)
			data_bit = code[`NMH_POS_TYPE - 1 - pos];
		else if (pos < `NMH_POS_WSC)
			data_bit = TYPE_BITS[`NMH_POS_WSC - 1 - pos];
		else if (pos < `NMH_POS_ALERT)
			data_bit = wsc[`NMH_POS_ALERT - 1 - pos];
		else if (pos == `NMH_POS_ALERT)
			data_bit = alert;
		else if (pos < `NMH_POS_HEALTH)
			data_bit = week[`NMH_POS_HEALTH - 1 - pos];
		else if (pos < `NMH_POS_EPOCH)
			data_bit = health[`NMH_POS_EPOCH - 1 - pos];
		else if (pos < `NMH_POS_ERRIDX)
			data_bit = epoch[`NMH_POS_ERRIDX - 1 - pos];
		else if (pos < `NMH_POS_BODY)
			data_bit = err_idx[`NMH_POS_BODY - 1 - pos];
		else if (pos < `NMH_POS_INTEG)
			data_bit = body[`NMH_POS_INTEG - 1 - pos];
		else if (pos == `NMH_POS_INTEG)
			data_bit = integ;
		else if (pos == `NMH_POS_PHASE)
			data_bit = phase;
		else if (pos < `NMH_POS_CRC)
			data_bit = 1'b0;
		else
			data_bit = crc[23];
	end

	assign crc_fb = data_bit ^ crc[23];
	// rate one-half encoder, k=7, one symbol pair per data bit
	assign fec_sym = {^({data_bit, fec_sr} & 7'h79), ^({data_bit, fec_sr} & 7'h5b)};

	// ----------------------------------------------------------------
	// state machine
	// ----------------------------------------------------------------
	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (i_start & o_start_ready)
					next_state = ST_SEND;
			end
			ST_SEND: begin
				if (send_bit && pos == `NMH_MSG_BITS)
					next_state = ST_DONE;
			end
			ST_DONE: begin
				next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= ST_IDLE;
			bit_pos <= 9'h000;
			crc <= 24'h000000;
			fec_sr <= 6'h00;
			wsc <= 17'h00000;
			code <= 6'h00;
			alert <= 1'b0;
		end else begin
			state <= next_state;
			if (state == ST_IDLE && next_state == ST_SEND) begin
				bit_pos <= 9'h000;
				crc <= 24'h000000;
				fec_sr <= 6'h00;
				wsc <= i_week_seconds_count;
				code <= i_satellite_code_number;
				alert <= i_alert;
			end else if (send_bit) begin
				bit_pos <= pos;
				fec_sr <= {data_bit, fec_sr[5:1]};
				if (pos < `NMH_POS_CRC)
					crc <= {crc[22:0], 1'b0} ^ (crc_fb ? `NMH_CRC_POLY : 24'h000000);
				else
					crc <= {crc[22:0], 1'b0};
			end
		end
	end

	// ----------------------------------------------------------------
	// data set store and lifetime
	// ----------------------------------------------------------------
	always @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			week <= 13'h0000;
			health <= 3'h7;
			epoch <= 11'h000;
			err_idx <= 5'h10;
			integ <= 1'b0;
			phase <= 1'b0;
			ref_time <= 11'h000;
			body <= {201{1'b0}};
			have_set <= 1'b0;
			set_age <= 44'h0;
			o_load_refused <= 1'b0;
			o_set_expired <= 1'b0;
			o_set_stale <= 1'b0;
		end else begin
			o_load_refused <= i_load & ~load_ok;
			if (load_ok) begin
				week <= i_week_count;
				if (i_upload | ~have_set)
					health <= i_health;
				epoch <= i_epoch;
				err_idx <= i_error_bound_index;
				integ <= i_integrity_level_flag;
				phase <= i_phase_flag;
				ref_time <= i_ephemeris_reference_time;
				body <= i_body;
				have_set <= 1'b1;
				set_age <= 44'h0;
				o_set_expired <= 1'b0;
				o_set_stale <= 1'b0;
			end else if (have_set) begin
				if (set_age != FIT_CYCLES[43:0])
					set_age <= set_age + 44'h1;
				if (set_age >= SET_CYCLES[43:0])
					o_set_expired <= 1'b1;
				if (set_age >= FIT_CYCLES[43:0])
					o_set_stale <= 1'b1;
			end
		end
	end

	nmh_fifo #(
		.WIDTH(2),
		.DEPTH(`NMH_FIFO_DEPTH),
		.AW(5)
	) u_fifo (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_in_valid(send_bit),
		.o_in_ready(fifo_in_ready),
		.i_in_data(fec_sym),
		.o_out_valid(o_sym_valid),
		.i_out_ready(i_sym_ready),
		.o_out_data(o_sym)
	);
endmodule

// file: dv/nmh_framer_checker.sv
// port assertions for the ephemeris message framer
// assumes one clock domain and an async active-low reset
`timescale 1ns/10ps
module nmh_framer_checker (
	input wire i_clk_sys,
	input wire i_rst_n,
	input wire i_load,
	input wire i_start,
	input wire i_sym_ready,
	input wire o_start_ready,
	input wire o_busy,
	input wire o_load_refused,
	input wire o_set_expired,
	input wire o_set_stale,
	input wire o_sym_valid,
	input wire [1:0] o_sym
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	chk_busy_load_refused: assert property (i_load && o_busy |=> o_load_refused)
		else $error("load while busy was not refused");
	chk_refuse_has_cause: assert property (o_load_refused |-> $past(i_load))
		else $error("refusal without a load");
	chk_start_gives_busy: assert property (i_start && o_start_ready |=> o_busy)
		else $error("start did not begin a message");
	chk_busy_not_ready: assert property (o_busy |-> !o_start_ready)
		else $error("start offered during a message");
	chk_busy_min_len: assert property ($rose(o_busy) |-> o_busy [*8])
		else $error("message ended too early");
	chk_first_sym_soon: assert property ($rose(o_busy) |-> ##[1:4] o_sym_valid)
		else $error("first symbol late");
	chk_sym_held: assert property (o_sym_valid && !i_sym_ready |=> o_sym_valid && $stable(o_sym))
		else $error("symbol dropped before taken");
	chk_expired_blocks: assert property (o_set_expired |-> !o_start_ready)
		else $error("expired set still offered");
	chk_stale_implies_old: assert property (o_set_stale |-> o_set_expired)
		else $error("stale without expired");
endmodule
bind nmh_framer nmh_framer_checker CHK (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_load(i_load),
	.i_start(i_start), .i_sym_ready(i_sym_ready), .o_start_ready(o_start_ready), .o_busy(o_busy),
	.o_load_refused(o_load_refused), .o_set_expired(o_set_expired), .o_set_stale(o_set_stale),
	.o_sym_valid(o_sym_valid), .o_sym(o_sym));

// file: dv/nmh_line_sink.sv
// receiver side: takes symbol pairs, fast or with stalls
// assumes the bench clears n between messages at a falling edge
`timescale 1ns/10ps
module nmh_line_sink (
	input wire clk,
	input wire rst_n,
	input wire slow,
	input wire sym_valid,
	input wire [1:0] sym,
	output logic ready = 1'b0
);
	logic [1:0] got [0:299];
	int n = 0;
	logic [1:0] c = 2'h0;
	// stalls three of four cycles so the fifo fills
	always @(negedge clk) begin
		c <= c + 2'h1;
		ready <= rst_n && (!slow || c == 2'h0);
	end
	always @(posedge clk) begin
		if (sym_valid && ready && n < 300) begin
			got[n] <= sym;
			n <= n + 1;
		end
	end
endmodule

// file: dv/test_nav_msg_ephemeris_header_fields.sv
// self-checking bench for the ephemeris message framer
// assumes fec state cleared at each message start
`timescale 1ns/10ps
module test_nav_msg_ephemeris_header_fields;
	logic clk = 0, rst_n = 0, ld = 0, up = 0, st = 0, integ = 0, ph = 0, alert = 0, slow = 0;
	logic [12:0] wk = 0;
	logic [2:0] hl = 0, hx = 0;
	logic [10:0] ep = 0, rt = 0;
	logic [4:0] ix = 0;
	logic [200:0] bd = 0;
	logic [5:0] code = 0;
	logic [16:0] wsc = 0;
	wire rdy, s_rdy, busy, refd, expd, stale, sv;
	wire [1:0] sym;
	int n_fail = 0, n_tests = 0;
	always #4 clk = ~clk;
	nmh_framer DUT (.i_clk_sys(clk), .i_rst_n(rst_n), .i_load(ld), .i_upload(up), .i_week_count(wk),
		.i_health(hl), .i_epoch(ep), .i_error_bound_index(ix), .i_integrity_level_flag(integ),
		.i_phase_flag(ph), .i_ephemeris_reference_time(rt), .i_body(bd), .i_satellite_code_number(code),
		.i_alert(alert), .i_start(st), .i_week_seconds_count(wsc), .i_sym_ready(s_rdy), .o_start_ready(rdy),
		.o_busy(busy), .o_load_refused(refd), .o_set_expired(expd), .o_set_stale(stale),
		.o_sym_valid(sv), .o_sym(sym));
	nmh_line_sink LINE (.clk(clk), .rst_n(rst_n), .slow(slow), .sym_valid(sv), .sym(sym), .ready(s_rdy));
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task load(input logic bad);
		logic r;
		@(negedge clk) ld = 1;
		@(negedge clk) ld = 0;
		r = refd;
		@(negedge clk) r = r | refd;
		chk("refused", bad, r);
	endtask
	// whole message; pb also tries a load mid-message
	task msg(input logic pb);
		logic [299:0] b;
		logic [6:0] s;
		logic [23:0] c;
		b = {8'h8b, code, 6'h0a, wsc, alert, wk, hx, ep, ix, bd, integ, ph, 3'h0, 24'h000000};
		c = 24'h000000;
		for (int i = 0; i < 276; i++)
			c = {c[22:0], 1'b0} ^ ((b[299-i] ^ c[23]) ? 24'h864cfb : 24'h000000);
		b[23:0] = c;
		LINE.n = 0;
		chk("ready", 1, rdy);
		@(negedge clk) st = 1;
		@(negedge clk) st = 0;
		chk("busy", 1, busy);
		if (pb) load(1);
		for (int k = 0; k < 20000 && LINE.n < 300; k++) @(negedge clk);
		chk("count", 300, LINE.n);
		s = 7'h00;
		for (int i = 0; i < 300; i++) begin
			s = {b[299-i], s[6:1]};
			chk("sym", {^(s & 7'h79), ^(s & 7'h5b)}, LINE.got[i]);
		end
		$display("message test done");
	endtask
	task end_of_test;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		#400000 n_fail++;
		end_of_test;
	end
	initial begin
		#24 rst_n = 1;
		chk("ready after reset", 0, rdy);
		wk = 13'h1fff; hl = 3'h5; hx = 3'h5; ep = 11'h5a5; ix = 5'h10; rt = 11'h0c3;
		bd = {67{3'h6}}; code = 6'h2a; wsc = 17'h12345; alert = 1; integ = 1; up = 1;
		load(0);
		msg(0);
		slow = 1; ix = 5'h0f; integ = 0; ph = 1; hl = 3'h2; alert = 0; rt = 11'h0c4; up = 0; bd = ~bd;
		load(0);
		msg(1);
		bd = {201{1'h1}};
		load(1);
		bd = ~{67{3'h6}}; up = 1;
		load(1);
		rt = 11'h0c5; hx = 3'h2; slow = 0;
		load(0);
		msg(0);
		end_of_test;
	end
endmodule
